/* File: hw/srfe_top.sv */
// Two-wire slave front end of a 256-byte memory: framing, addressing, page writes.
// Assumes each bus clock phase spans several system clocks and floating selects pull low.
//
// Functional notes
// [RQ1] Respond to nothing until SDA falls while SCL is high.
// [RQ2] SDA rising while SCL high is a stop; every operation ends with one.
// [RQ3] Any SDA change with SCL high is taken as start or stop.
// [RQ4] One SCL pulse per bit; SDA sampled once per high phase.
// [RQ5] The receiver acknowledges each byte by pulling SDA low on the next pulse.
// [RQ6] Accept an address byte only with type 1010 and matching select pins.
// [RQ7] Address bit zero selects direction: one reads, zero writes.
// [RQ8] On a matching address, drive SDA low during the ninth clock.
// [RQ9] Unconnected select pins count as zero; eight devices may share a bus.
// [RQ10] Write protect high blocks programming of the whole array.
// [RQ11] Byte write: write address, pointer byte, one data byte, each acknowledged.
// [RQ12] A stop after a write starts programming; requests are ignored meanwhile.
// [RQ13] A page write carries up to sixteen data bytes, each acknowledged at once.
// [RQ14] Each data byte steps the low four pointer bits; upper bits hold.
// [RQ15] More than sixteen bytes wrap and overwrite earlier buffered bytes.
// [RQ16] All bytes of one page write are programmed together after the stop.
// [RQ17] Address polls are refused while programming and acknowledged afterwards.
// [RQ18] A start resets the protocol logic; the master may clock out a stuck bus.
// [RQ19] Standby after reset, after a non-write stop, or when programming ends.
// [RQ20] The master starts only on an idle bus and brackets transfers.
// [RQ21] SDA is open drain: only pulled low, otherwise released.
// [RQ22] Only the master makes SCL, starts and stops; this device is a slave.
// [RQ23] The pointer byte addresses all 256 bytes directly.
// [RQ24] The pointer ends as the last accessed address plus one; after the last byte of a page it wraps to that page's first byte.
// [RQ25] Protected writes are acknowledged, never programmed, and return to standby.
// [RQ26] A start or stop inside a byte abandons the write unprogrammed.
`timescale 1ns/1ps
module srfe_top
    import srfe_pkg::*;
#(
    parameter int PROG_CYCLES = SRFE_PROG_CYC
) (
    // System clock and reset
    input  wire logic       CLOCK,
    input  wire logic       NRST,
    // Two-wire bus
    input  wire logic       SCL,
    input  wire logic       SDA_I,
    output logic            SDA_O,
    output logic            SDA_OE_N,
    // Board straps
    input  wire logic       SELECT_PIN_BIT0,
    input  wire logic       SELECT_PIN_BIT1,
    input  wire logic       SELECT_PIN_BIT2,
    input  wire logic       WRITE_PROTECT,
    // Array observation
    input  wire logic [7:0] PEEK_ADDR,
    output logic [7:0]      PEEK_DATA,
    // Status
    output logic            BUSY,
    output logic            STANDBY
);
    logic [SRFE_SY_W-1:0]   sy;
    logic                   cap_bit;
    logic                   cap_tog;
    logic                   s_scl;
    logic                   s_sda;
    logic [2:0]             s_sel;
    logic                   s_wp;
    logic                   s_tog;
    logic                   scl_p_q;
    logic                   sda_p_q;
    logic                   tog_p_q;
    srfe_ev_s               ev;
    srfe_state_e            state_q;
    logic [3:0]             cnt_q;
    logic [7:0]             shift_q;
    logic [7:0]             byte_v;
    logic                   active;
    logic                   byte_done;
    logic                   addr_match;
    logic                   ack_ok;
    logic                   in_ack_q;
    logic                   ack_pend_q;
    logic                   ninth_q;
    logic                   sda_oe_n_q;
    srfe_ptr_s              ptr_q;
    srfe_ptr_s              peek;
    logic [SRFE_PAGE_BYTES-1:0] vld;
    logic [7:0]             slot_rd [SRFE_PAGE_BYTES];
    logic                   busy_q;
    logic [SRFE_PROG_W-1:0] prog_cnt_q;
    logic                   prog_start;
    logic                   prog_done;
    logic [7:0]             peek_q;

    // The master alone clocks this sampler. [RQ22]
    srfe_bit_capture u_cap (
        .scl_clk (SCL),
        .rst_n   (NRST),
        .sda     (SDA_I),
        .bit_q   (cap_bit),
        .tog_q   (cap_tog)
    );

    srfe_sync3 #(
        .W   (SRFE_SY_W),
        .RST (SRFE_SY_RST)
    ) u_sync (
        .clk   (CLOCK),
        .rst_n (NRST),
        .d     ({cap_tog, WRITE_PROTECT, SELECT_PIN_BIT2, SELECT_PIN_BIT1, SELECT_PIN_BIT0, SDA_I, SCL}),
        .q     (sy)
    );

    assign s_scl = sy[SRFE_SY_SCL];
    assign s_sda = sy[SRFE_SY_SDA];
    assign s_sel = sy[SRFE_SY_SEL +: 3];
    assign s_wp  = sy[SRFE_SY_WP];
    assign s_tog = sy[SRFE_SY_TOG];

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            scl_p_q <= 1'h1;
            sda_p_q <= 1'h1;
            tog_p_q <= 1'h0;
        end else begin
            scl_p_q <= s_scl;
            sda_p_q <= s_sda;
            tog_p_q <= s_tog;
        end
    end

    // SCL and SDA share one synchroniser depth, so a data change needs a hold time
    // of a couple of system clocks after SCL falls to avoid a false condition.
    assign ev.start  = scl_p_q & s_scl & sda_p_q & ~s_sda; // [RQ3]
    assign ev.stop   = scl_p_q & s_scl & ~sda_p_q & s_sda; // [RQ2]
    assign ev.fall   = scl_p_q & ~s_scl;
    assign ev.bit_ev = tog_p_q ^ s_tog; // [RQ4]

    // The captured bit is stable here because its toggle has just crossed.
    assign byte_v     = {shift_q[6:0], cap_bit};
    assign active     = (state_q != ST_IDLE) && (state_q != ST_IGNORE);
    assign byte_done  = ev.bit_ev && !in_ack_q && active && (cnt_q == SRFE_BIT_LAST);
    // Floating select pins are pulled low at the pads, so they match as zero. [RQ9]
    assign addr_match = (byte_v[7:4] == SRFE_DEV_TYPE) && (byte_v[3:1] == s_sel) && !busy_q; // [RQ6]

    always_comb begin
        unique case (state_q)
            ST_ADDR: ack_ok = addr_match; // [RQ17]
            ST_WORD: ack_ok = 1'h1; // [RQ11]
            ST_DATA: ack_ok = 1'h1; // [RQ13]
            default: ack_ok = 1'h0;
        endcase
    end

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            state_q <= ST_IDLE;
        end else if (ev.start) begin
            state_q <= ST_ADDR; // [RQ18]
        end else if (ev.stop) begin
            state_q <= ST_IDLE; // [RQ19]
        end else if (byte_done) begin
            unique case (state_q)
                ST_ADDR: begin
                    if (!addr_match) begin
                        state_q <= ST_IGNORE; // [RQ12]
                    end else if (byte_v[0] == SRFE_DIR_READ) begin
                        state_q <= ST_READ; // [RQ7]
                    end else begin
                        state_q <= ST_WORD;
                    end
                end
                ST_WORD: state_q <= ST_DATA;
                default: state_q <= state_q;
            endcase
        end
    end

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            cnt_q   <= '0;
            shift_q <= '0;
        end else if (ev.start || ev.stop) begin
            cnt_q   <= '0;
        end else if (ev.bit_ev && !in_ack_q && active) begin
            shift_q <= byte_v;
            if (cnt_q == SRFE_BIT_LAST) begin
                cnt_q <= '0;
            end else begin
                cnt_q <= cnt_q + SRFE_BIT_STEP;
            end
        end
    end

    // The ack phase spans the capture of the eighth bit up to the fall after the ninth.
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            in_ack_q   <= 1'h0;
            ack_pend_q <= 1'h0;
            ninth_q    <= 1'h0;
        end else if (ev.start || ev.stop) begin
            in_ack_q   <= 1'h0;
            ack_pend_q <= 1'h0;
            ninth_q    <= 1'h0;
        end else if (byte_done) begin
            in_ack_q   <= 1'h1;
            ack_pend_q <= ack_ok; // [RQ5]
            ninth_q    <= 1'h0;
        end else if (in_ack_q && ev.bit_ev) begin
            ninth_q    <= 1'h1;
        end else if (in_ack_q && ev.fall && ninth_q) begin
            in_ack_q   <= 1'h0;
            ack_pend_q <= 1'h0;
            ninth_q    <= 1'h0;
        end
    end

    // Changing SDA only after SCL falls keeps the ack clear of start and stop.
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            sda_oe_n_q <= 1'h1;
        end else if (ev.start || ev.stop) begin
            sda_oe_n_q <= 1'h1;
        end else if (in_ack_q && ev.fall && ninth_q) begin
            sda_oe_n_q <= 1'h1; // [RQ21]
        end else if (in_ack_q && ack_pend_q && ev.fall) begin
            sda_oe_n_q <= 1'h0; // [RQ8]
        end
    end

    assign SDA_O    = SRFE_SDA_LOW;
    assign SDA_OE_N = sda_oe_n_q;

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            ptr_q <= '0;
        end else if (byte_done && state_q == ST_WORD) begin
            ptr_q <= byte_v; // [RQ23]
        end else if (byte_done && state_q == ST_DATA) begin
            ptr_q.offs <= ptr_q.offs + SRFE_OFFS_STEP; // [RQ14] [RQ24]
        end
    end

    // The stop rides on a clock pulse that is taken as one bit, so a stop on a byte boundary sees a count of one.
    // Any other count, an open acknowledge or a protect level leaves the buffer unprogrammed.
    assign prog_start = ev.stop && (state_q == ST_DATA) && (cnt_q == SRFE_BIT_STEP) && !in_ack_q // [RQ26]
                        && (|vld) && !s_wp && !busy_q; // [RQ10] [RQ25]
    assign prog_done  = busy_q && (prog_cnt_q == '0);

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            busy_q     <= 1'h0;
            prog_cnt_q <= '0;
        end else if (prog_start) begin
            busy_q     <= 1'h1; // [RQ12]
            prog_cnt_q <= SRFE_PROG_W'(PROG_CYCLES - 1);
        end else if (prog_done) begin
            busy_q     <= 1'h0; // [RQ19]
        end else if (busy_q) begin
            prog_cnt_q <= prog_cnt_q - SRFE_PROG_ONE;
        end
    end

    assign peek = PEEK_ADDR;

    genvar i;
    generate
        for (i = 0; i < SRFE_PAGE_BYTES; i++) begin : g_slot
            logic [7:0] buf_q;
            logic       vld_q;
            logic [7:0] col_q [SRFE_PAGES];

            // Polling starts during programming must not drop the page being written.
            always_ff @(posedge CLOCK or negedge NRST) begin
                if (!NRST) begin
                    buf_q <= '0;
                    vld_q <= 1'h0;
                end else if (prog_done || (ev.start && !busy_q)) begin
                    vld_q <= 1'h0; // [RQ26]
                end else if (byte_done && state_q == ST_DATA && ptr_q.offs == 4'(i)) begin
                    buf_q <= byte_v; // [RQ15]
                    vld_q <= 1'h1;
                end
            end

            // Untouched bytes of the page keep their old contents.
            always_ff @(posedge CLOCK or negedge NRST) begin
                if (!NRST) begin
                    for (int p = 0; p < SRFE_PAGES; p++) begin
                        col_q[p] <= SRFE_ERASED;
                    end
                end else if (prog_done && vld_q) begin
                    col_q[ptr_q.page] <= buf_q; // [RQ16]
                end
            end

            assign vld[i]     = vld_q;
            assign slot_rd[i] = col_q[peek.page];
        end
    endgenerate

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            peek_q <= '0;
        end else begin
            peek_q <= slot_rd[peek.offs];
        end
    end

    assign PEEK_DATA = peek_q;
    assign BUSY      = busy_q;
    assign STANDBY   = (state_q == ST_IDLE) && !busy_q; // [RQ19]

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!NRST);

    sequence ack_armed_s;
        byte_done && ack_ok && !ev.start && !ev.stop;
    endsequence

    sequence ack_fall_s;
        in_ack_q && ack_pend_q && !ninth_q && ev.fall;
    endsequence

    idle_hold_a: assert property ( // [RQ1]
        state_q == ST_IDLE && !ev.start |=> state_q == ST_IDLE
    ) else $error("left idle without a start");

    stop_idle_a: assert property ( // [RQ2]
        ev.stop |=> state_q == ST_IDLE && sda_oe_n_q
    ) else $error("stop did not return to idle");

    start_reset_a: assert property ( // [RQ18]
        ev.start |=> state_q == ST_ADDR && cnt_q == '0 && !in_ack_q
    ) else $error("start did not reset framing");

    addr_type_a: assert property ( // [RQ6]
        byte_done && state_q == ST_ADDR && byte_v[7:4] != SRFE_DEV_TYPE |=> state_q == ST_IGNORE
    ) else $error("wrong device type accepted");

    addr_sel_a: assert property ( // [RQ9]
        byte_done && state_q == ST_ADDR && byte_v[3:1] != s_sel |=> state_q == ST_IGNORE && !ack_pend_q
    ) else $error("select mismatch accepted");

    addr_dir_a: assert property ( // [RQ7]
        byte_done && state_q == ST_ADDR && addr_match |=> state_q == ($past(byte_v[0]) ? ST_READ : ST_WORD)
    ) else $error("direction bit misread");

    ack_drive_a: assert property ( // [RQ8]
        ack_armed_s ##[1:40] ack_fall_s |=> !sda_oe_n_q && in_ack_q
    ) else $error("acknowledge not driven");

    ack_release_a: assert property ( // [RQ5]
        in_ack_q && ninth_q && ev.fall && !ev.stop |=> sda_oe_n_q && !in_ack_q
    ) else $error("acknowledge not released");

    open_drain_a: assert property ( // [RQ21]
        !sda_oe_n_q |-> in_ack_q && ack_pend_q && SDA_O == SRFE_SDA_LOW
    ) else $error("SDA driven outside an acknowledge");

    poll_busy_a: assert property ( // [RQ17]
        busy_q && byte_done && state_q == ST_ADDR |=> state_q == ST_IGNORE && !ack_pend_q
    ) else $error("address acknowledged while programming");

    word_load_a: assert property ( // [RQ11]
        byte_done && state_q == ST_WORD |=> ptr_q == $past(byte_v) && state_q == ST_DATA
    ) else $error("pointer byte not loaded");

    page_wrap_a: assert property ( // [RQ14]
        byte_done && state_q == ST_DATA |=> ptr_q.page == $past(ptr_q.page) && ptr_q.offs == $past(ptr_q.offs) + SRFE_OFFS_STEP
    ) else $error("pointer step wrong");

    prog_load_a: assert property ( // [RQ12]
        prog_start |=> busy_q && prog_cnt_q == SRFE_PROG_W'(PROG_CYCLES - 1)
    ) else $error("program cycle not started");

    wp_block_a: assert property ( // [RQ10]
        ev.stop && s_wp && !busy_q |=> !busy_q
    ) else $error("programming under write protect");

    partial_drop_a: assert property ( // [RQ26]
        ev.stop && cnt_q != SRFE_BIT_STEP && !busy_q |=> !busy_q
    ) else $error("partial byte programmed");

    standby_end_a: assert property ( // [RQ19]
        prog_done && state_q == ST_IDLE && !ev.start |=> STANDBY
    ) else $error("no standby after programming");
endmodule

/* File: hw/srfe_pkg.sv */
// Constants and types shared by the serial memory write front end.
// Assumes a 40 MHz system clock and a master that owns the bus clock.
package srfe_pkg;
    localparam logic [3:0] SRFE_DEV_TYPE   = 4'ha;
    localparam logic       SRFE_DIR_READ   = 1'h1;
    localparam logic       SRFE_SDA_LOW    = 1'h0;
    localparam logic [3:0] SRFE_BIT_LAST   = 4'h7;
    localparam logic [3:0] SRFE_BIT_STEP   = 4'h1;
    localparam logic [3:0] SRFE_OFFS_STEP  = 4'h1;
    localparam int         SRFE_PAGE_BYTES = 16;
    localparam int         SRFE_PAGES      = 16;
    localparam logic [7:0] SRFE_ERASED     = 8'hff;
    localparam int         SRFE_CLK_HZ     = 40000000;
    localparam int         SRFE_PROG_US    = 4000;
    localparam int         SRFE_PROG_CYC   = SRFE_PROG_US * (SRFE_CLK_HZ / 1000000);
    localparam int         SRFE_PROG_W     = 18;
    localparam logic [SRFE_PROG_W-1:0] SRFE_PROG_ONE = 18'h1;
    // Positions in the synchronised pin vector.
    localparam int         SRFE_SY_SCL     = 0;
    localparam int         SRFE_SY_SDA     = 1;
    localparam int         SRFE_SY_SEL     = 2;
    localparam int         SRFE_SY_WP      = 5;
    localparam int         SRFE_SY_TOG     = 6;
    localparam int         SRFE_SY_W       = 7;
    localparam logic [6:0] SRFE_SY_RST     = 7'h03;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_WORD,
        ST_DATA,
        ST_READ,
        ST_IGNORE
    } srfe_state_e;

    typedef struct packed {
        logic [3:0] page;
        logic [3:0] offs;
    } srfe_ptr_s;

    typedef struct packed {
        logic start;
        logic stop;
        logic fall;
        logic bit_ev;
    } srfe_ev_s;
endpackage

/* File: hw/srfe_sync3.sv */
// Three-stage pin synchroniser with an agreement filter per bit.
// Assumes each input may change at any time relative to clk.
`timescale 1ns/1ps
module srfe_sync3
    import srfe_pkg::*;
#(
    parameter int           W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Levels in and filtered levels out
    input  wire logic [W-1:0] d,
    output logic [W-1:0]      q
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic s1_q;
            logic s2_q;
            logic s3_q;
            logic o_q;
            // The output moves only once the second and third stages agree.
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    s1_q <= RST[i];
                    s2_q <= RST[i];
                    s3_q <= RST[i];
                    o_q  <= RST[i];
                end else begin
                    s1_q <= d[i];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q) begin
                        o_q <= s3_q;
                    end
                end
            end
            assign q[i] = o_q;
        end
    endgenerate
endmodule

/* File: hw/srfe_bit_capture.sv */
// Bit sampler that runs on the bus clock itself.
// Assumes the sampled bit is read only after its toggle has crossed over.
`timescale 1ns/1ps
module srfe_bit_capture
    import srfe_pkg::*;
(
    // Bus clock and reset
    input  wire logic scl_clk,
    input  wire logic rst_n,
    // Serial data in
    input  wire logic sda,
    // Captured bit and its event toggle
    output logic      bit_q,
    output logic      tog_q
);
    // The bit stays put for a whole bus period, long enough for the toggle to cross.
    always_ff @(posedge scl_clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_q <= 1'h1;
        end else begin
            bit_q <= sda; // [RQ4]
        end
    end

    always_ff @(posedge scl_clk or negedge rst_n) begin
        if (!rst_n) begin
            tog_q <= 1'h0;
        end else begin
            tog_q <= ~tog_q;
        end
    end
endmodule

/* File: verification/srfe_master_model.sv */
// Two-wire bus master model that frames and clocks traffic for the front end.
// Assumes the device pulls SDA through an active low enable and a pull-up holds it high.
`timescale 1ns/1ps
module srfe_master_model (
    // Phase timing
    input  wire logic clk,
    // Device pull on the data wire
    input  wire logic sda_oe_n,
    // Bus wires
    output logic      scl,
    output wire logic sda
);
    logic drv_low = 1'h0;

    initial scl = 1'h1;
    // The pull-up wins unless one of the parties pulls low.
    assign sda = ~drv_low & sda_oe_n;

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Data moves only mid-way through the low phase, five cycles clear of either edge.
    task automatic clk_bit(input logic b, output logic s);
        wt(5);
        drv_low <= ~b;
        wt(5);
        scl <= 1'h1;
        wt(5);
        s = sda;
        wt(5);
        scl <= 1'h0;
    endtask

    task automatic send_bits(input logic [7:0] b, input int n);
        logic s;
        for (int i = 0; i < n; i++) begin
            clk_bit(b[7-i], s);
        end
    endtask

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        send_bits(b, 8);
        clk_bit(1'h1, s);
        ack = ~s;
    endtask

    task automatic start();
        wt(5);
        drv_low <= 1'h0;
        wt(5);
        scl <= 1'h1;
        wt(5);
        drv_low <= 1'h1;
        wt(5);
        scl <= 1'h0;
    endtask

    // The bus is left idle afterwards: clock high and data released.
    task automatic stop();
        wt(5);
        drv_low <= 1'h1;
        wt(5);
        scl <= 1'h1;
        wt(5);
        drv_low <= 1'h0;
        wt(20);
    endtask
endmodule

/* File: verification/tb_serial_eeprom_slave_write_front_end.sv */
// Self-checking bench for the two-wire memory write front end.
// Assumes the master model in srfe_master_model and a shortened program cycle.
`timescale 1ns/1ps
module tb_serial_eeprom_slave_write_front_end;
    import srfe_pkg::*;
    logic       clock     = 1'h0;
    logic       nrst      = 1'h0;
    logic [2:0] sel       = 3'h0;
    logic       wp        = 1'h0;
    logic [7:0] peek_addr = 8'h0;
    logic [7:0] peek_data;
    logic       sda_o;
    logic       sda_oe_n;
    logic       busy;
    logic       standby;
    wire logic  scl;
    wire logic  sda;
    int         fail_count = 0;
    int         n_tests    = 0;

    always #12.5 clock = ~clock;

    srfe_master_model m (.clk(clock), .sda_oe_n(sda_oe_n), .scl(scl), .sda(sda));

    // A long program cycle keeps the device busy through a whole poll.
    srfe_top #(.PROG_CYCLES(1000)) DUT (
        .CLOCK(clock), .NRST(nrst), .SCL(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_N(sda_oe_n),
        .SELECT_PIN_BIT0(sel[0]), .SELECT_PIN_BIT1(sel[1]), .SELECT_PIN_BIT2(sel[2]),
        .WRITE_PROTECT(wp), .PEEK_ADDR(peek_addr), .PEEK_DATA(peek_data), .BUSY(busy), .STANDBY(standby)
    );

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic peek(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        peek_addr <= a;
        repeat (3) @(negedge clock);
        chk(peek_data, exp);
    endtask

    task automatic wait_busy(input logic v, input int n);
        int i;
        for (i = 0; i < n && busy !== v; i++) begin
            @(negedge clock);
        end
        chk({7'h0, busy}, {7'h0, v});
        if (busy !== v) wrap_up();
    endtask

    task automatic addr(input logic [7:0] a, input logic exp);
        logic ack;
        m.start();
        m.send_byte(a, ack);
        chk({7'h0, ack}, {7'h0, exp});
    endtask

    task automatic wseq(input logic [7:0] ptr, input logic [7:0] base, input int n);
        logic ack;
        addr({SRFE_DEV_TYPE, 4'h0}, 1'h1);
        m.send_byte(ptr, ack);
        chk({7'h0, ack}, 8'h1);
        for (int i = 0; i < n; i++) begin
            m.send_byte(base + i[7:0], ack);
            chk({7'h0, ack}, 8'h1);
        end
    endtask

    task automatic t_reset();
        logic ack;
        chk({6'h0, sda_o, sda_oe_n}, 8'h1);
        chk({6'h0, busy, standby}, 8'h1);
        peek(8'h00, SRFE_ERASED);
        @(posedge clock);
        m.send_byte({SRFE_DEV_TYPE, 4'h0}, ack);
        chk({7'h0, ack}, 8'h0);
        m.stop();
    endtask

    task automatic t_select();
        for (int s = 0; s < 8; s++) begin
            sel <= s[2:0];
            m.wt(10);
            addr({SRFE_DEV_TYPE, s[2:0], 1'h0}, 1'h1);
            m.stop();
            addr({SRFE_DEV_TYPE, s[2:0], 1'h1}, 1'h1);
            m.stop();
            addr({SRFE_DEV_TYPE, ~s[2:0], 1'h0}, 1'h0);
            m.stop();
            addr({4'hb, s[2:0], 1'h0}, 1'h0);
            m.stop();
            chk({6'h0, busy, standby}, 8'h1);
        end
        sel <= 3'h0;
    endtask

    task automatic t_byte();
        wseq(8'h37, 8'h5a, 1);
        m.stop();
        wait_busy(1'h1, 40);
        addr({SRFE_DEV_TYPE, 4'h0}, 1'h0);
        m.stop();
        wait_busy(1'h0, 2000);
        chk({7'h0, standby}, 8'h1);
        peek(8'h37, 8'h5a);
        @(posedge clock);
        addr({SRFE_DEV_TYPE, 4'h0}, 1'h1);
        m.stop();
    endtask

    task automatic t_page();
        logic [7:0] e [16];
        for (int i = 0; i < 18; i++) e[(14 + i) % 16] = 8'h10 + i[7:0];
        wseq(8'h2e, 8'h10, 18);
        peek(8'h2e, SRFE_ERASED);
        @(posedge clock);
        m.stop();
        wait_busy(1'h1, 40);
        wait_busy(1'h0, 2000);
        for (int i = 0; i < 16; i++) peek({4'h2, i[3:0]}, e[i]);
        peek(8'h1f, SRFE_ERASED);
        peek(8'h30, SRFE_ERASED);
    endtask

    task automatic t_protect();
        @(posedge clock);
        wp <= 1'h1;
        wseq(8'h50, 8'h33, 2);
        m.stop();
        chk({6'h0, busy, standby}, 8'h1);
        peek(8'h50, SRFE_ERASED);
        @(posedge clock);
        wp <= 1'h0;
    endtask

    // A restart inside a byte must drop the first write, a stop inside a byte too.
    task automatic t_abort();
        wseq(8'h60, 8'h11, 1);
        m.send_bits(8'h55, 3);
        wseq(8'h61, 8'h22, 1);
        m.stop();
        wait_busy(1'h1, 40);
        wait_busy(1'h0, 2000);
        peek(8'h61, 8'h22);
        peek(8'h60, SRFE_ERASED);
        @(posedge clock);
        wseq(8'h70, 8'h44, 1);
        m.send_bits(8'h0f, 4);
        m.stop();
        chk({6'h0, busy, standby}, 8'h1);
        peek(8'h70, SRFE_ERASED);
    endtask

    initial begin
        repeat (6) @(posedge clock);
        nrst <= 1'h1;
        repeat (8) @(posedge clock);
        t_reset();
        t_select();
        t_byte();
        t_page();
        t_protect();
        t_abort();
        wrap_up();
    end
endmodule
